/* ocd_defines.vh */
// Register indices, field positions, reset values and encodings of the output divider channel
`ifndef OCD_DEFINES_VH
`define OCD_DEFINES_VH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define OCD_IDX_DIV1_ROUTE 10'h195
`define OCD_IDX_DIV2_COUNTS 10'h196
`define OCD_IDX_DIV2_CTRL 10'h197
`define OCD_IDX_DIV2_ROUTE 10'h198
`define OCD_IDX_INPUT_SEL 10'h1E1
`define OCD_IDX_STATUS 10'h1F0

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define OCD_CNT_LOW 7:4
`define OCD_CNT_HIGH 3:0
`define OCD_CTL_BYPASS 7
`define OCD_CTL_NOSYNC 6
`define OCD_CTL_FORCE 5
`define OCD_CTL_START 4
`define OCD_CTL_PHASE 3:0
`define OCD_RT_DIRECT 1
`define OCD_RT_DCC_OFF 0
`define OCD_SEL_VCO 1
`define OCD_SEL_BYP 0
`define OCD_SEL_FIELD 1:0

// ---------------------------------------------------------------
// Reset values and encodings
// ---------------------------------------------------------------
`define OCD_RST_BYTE 8'h00
`define OCD_RST_NIB 4'h0
`define OCD_ROUTE_VCO 2'h2
`define OCD_ROUTE_EXT 2'h0
`define OCD_NIB_ONE 4'h1
`define OCD_ZERO_WORD 32'h00000000

`endif

/* ocd_sync3.v */
// Three-flop pin synchroniser that accepts a change once the last two stages agree
`timescale 1ns/100ps
module ocd_sync3 (
   input wire clk_in,
   input wire rst_in,
   input wire pin_in,
   output reg level_out
);
   reg s1;
   reg s2;
   reg s3;

   // Shift the pin through three stages; only s2 and s3 are compared
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         level_out <= 1'b0;
      end else begin
         s1 <= pin_in;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level_out <= s3;
         end
      end
   end
endmodule

/* ocd_div_core.v */
// Divide-by-(low+1)+(high+1) counter with start level and phase offset restart
`timescale 1ns/100ps
`include "ocd_defines.vh"
module ocd_div_core (
   input wire clk_in,
   input wire rst_in,
   input wire hold_in,
   input wire restart_in,
   input wire [3:0] low_cnt_in,
   input wire [3:0] high_cnt_in,
   input wire start_high_in,
   input wire [3:0] phase_in,
   output reg level_out,
   output wire running_out
);
   localparam ST_HOLD = 3'b001;
   localparam ST_DELAY = 3'b010;
   localparam ST_RUN = 3'b100;

   reg [2:0] state;
   reg [3:0] cnt;

   assign running_out = state[2];

   // Hold at start level, wait out the phase offset, then count the two phases
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= ST_HOLD;
         cnt <= `OCD_RST_NIB;
         level_out <= 1'b0;
      end else if (hold_in) begin
         state <= ST_HOLD;
         level_out <= start_high_in;
      end else if (restart_in) begin
         level_out <= start_high_in;
         if (phase_in == `OCD_RST_NIB) begin
            state <= ST_RUN;
            cnt <= start_high_in ? high_cnt_in : low_cnt_in;
         end else begin
            state <= ST_DELAY;
            cnt <= phase_in - `OCD_NIB_ONE;
         end
      end else begin
         case (state)
            ST_HOLD: begin
               level_out <= start_high_in;
            end
            ST_DELAY: begin
               if (cnt == `OCD_RST_NIB) begin
                  state <= ST_RUN;
                  cnt <= start_high_in ? high_cnt_in : low_cnt_in;
               end else begin
                  cnt <= cnt - `OCD_NIB_ONE;
               end
            end
            ST_RUN: begin
               if (cnt == `OCD_RST_NIB) begin
                  level_out <= ~level_out;
                  cnt <= level_out ? low_cnt_in : high_cnt_in;
               end else begin
                  cnt <= cnt - `OCD_NIB_ONE;
               end
            end
            default: begin
               state <= ST_HOLD;
            end
         endcase
      end
   end
endmodule

/* ocd_channel.v */
// Output divider channel: register file, divider 2, sync handling and pair routing
// Function
// - low phase lasts low field plus one
// - high phase lasts high field plus one
// - bypass passes input clock past divider
// - sync ignore bit masks chip sync
// - force bit sets static level when ignoring
// - force bit ignored while bypass set
// - start bit picks initial output level
// - phase field delays divider start
// - divider 1 direct routes VCO
// - divider 1 direct routes external clock
// - divider 2 direct routes VCO
// - divider 2 direct routes external clock
// - correction disable bit switches correction off
// - select bit 1 picks VCO source
// - select bit 0 bypasses VCO divider unless select bit 1 is also written
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
`include "ocd_defines.vh"
module ocd_channel (
   input wire SYS_CLK_IN,
   input wire SYS_RST_IN,
   input wire WB_CYC_IN,
   input wire WB_STB_IN,
   input wire WB_WE_IN,
   input wire [11:0] WB_ADR_IN,
   input wire [3:0] WB_SEL_IN,
   input wire [31:0] WB_DAT_IN,
   output reg [31:0] WB_DAT_OUT,
   output reg WB_ACK_OUT,
   input wire VCO_CLK_IN,
   input wire EXT_CLK_IN,
   input wire SYNC_REQ_IN,
   input wire DIV1_LEVEL_IN,
   output reg PAIR_B_OUTPUT_A_OUT,
   output reg PAIR_B_OUTPUT_B_OUT,
   output reg PAIR_C_OUTPUT_A_OUT,
   output reg PAIR_C_OUTPUT_B_OUT,
   output reg [1:0] DUTY_CORRECTION_DISABLE_OUT,
   output reg VCO_DIV_SRC_VCO_OUT,
   output reg VCO_DIV_BYPASS_OUT
);

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   reg [7:0] div1_route_and_duty;
   reg [7:0] div2_cycle_counts;
   reg [7:0] div2_control;
   reg [7:0] div2_route_and_duty;
   reg [7:0] input_select;

   wire [9:0] reg_idx;
   wire bus_req;
   wire wr_req;
   wire [7:0] wr_byte;
   wire [7:0] status_byte;
   reg [7:0] next_rd_byte;
   reg [7:0] next_input_select;

   assign reg_idx = WB_ADR_IN[11:2];
   assign bus_req = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
   assign wr_req = bus_req & WB_WE_IN & WB_SEL_IN[0];
   assign wr_byte = WB_DAT_IN[7:0];

   // Source select write: VCO source wins over a requested divider bypass
   always @* begin
      next_input_select = `OCD_RST_BYTE;
      next_input_select[`OCD_SEL_VCO] = wr_byte[`OCD_SEL_VCO];
      next_input_select[`OCD_SEL_BYP] = wr_byte[`OCD_SEL_BYP] &
         ~wr_byte[`OCD_SEL_VCO];
   end

   // Register writes, low byte lane only
   always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         div1_route_and_duty <= `OCD_RST_BYTE;
         div2_cycle_counts <= `OCD_RST_BYTE;
         div2_control <= `OCD_RST_BYTE;
         div2_route_and_duty <= `OCD_RST_BYTE;
         input_select <= `OCD_RST_BYTE;
      end else if (wr_req) begin
         case (reg_idx)
            `OCD_IDX_DIV1_ROUTE: begin
               div1_route_and_duty <= {6'h00, wr_byte[1:0]};
            end
            `OCD_IDX_DIV2_COUNTS: begin
               div2_cycle_counts <= wr_byte;
            end
            `OCD_IDX_DIV2_CTRL: begin
               div2_control <= wr_byte;
            end
            `OCD_IDX_DIV2_ROUTE: begin
               div2_route_and_duty <= {6'h00, wr_byte[1:0]};
            end
            `OCD_IDX_INPUT_SEL: begin
               input_select <= next_input_select;
            end
            default: begin
               input_select <= input_select;
            end
         endcase
      end
   end

   // Read multiplexer; unmapped indices read as zero
   always @* begin
      case (reg_idx)
         `OCD_IDX_DIV1_ROUTE: next_rd_byte = div1_route_and_duty;
         `OCD_IDX_DIV2_COUNTS: next_rd_byte = div2_cycle_counts;
         `OCD_IDX_DIV2_CTRL: next_rd_byte = div2_control;
         `OCD_IDX_DIV2_ROUTE: next_rd_byte = div2_route_and_duty;
         `OCD_IDX_INPUT_SEL: next_rd_byte = input_select;
         `OCD_IDX_STATUS: next_rd_byte = status_byte;
         default: next_rd_byte = `OCD_RST_BYTE;
      endcase
   end

   // Single-wait-state acknowledge with registered read data
   always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         WB_ACK_OUT <= 1'b0;
         WB_DAT_OUT <= `OCD_ZERO_WORD;
      end else begin
         WB_ACK_OUT <= bus_req;
         if (bus_req & ~WB_WE_IN) begin
            WB_DAT_OUT <= {24'h000000, next_rd_byte};
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers for VCO, external clock and sync request
   // ---------------------------------------------------------------
   wire [2:0] pin_raw;
   wire [2:0] pin_lvl;
   wire vco_lvl;
   wire ext_lvl;
   wire sync_lvl;

   assign pin_raw = {SYNC_REQ_IN, EXT_CLK_IN, VCO_CLK_IN};
   assign vco_lvl = pin_lvl[0];
   assign ext_lvl = pin_lvl[1];
   assign sync_lvl = pin_lvl[2];

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
         ocd_sync3 u_sync (
            .clk_in(SYS_CLK_IN),
            .rst_in(SYS_RST_IN),
            .pin_in(pin_raw[gi]),
            .level_out(pin_lvl[gi])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Sync request handling
   // ---------------------------------------------------------------
   reg sync_prev;
   reg boot_start;
   wire obey_sync;
   wire sync_release;
   wire div_hold;
   wire div_restart;

   assign obey_sync = ~div2_control[`OCD_CTL_NOSYNC];
   assign sync_release = sync_prev & ~sync_lvl;
   // An obeying divider is held during sync and restarts on release
   assign div_hold = obey_sync & sync_lvl;
   assign div_restart = boot_start | (obey_sync & sync_release);

   // Edge tracking of the cleaned sync level and first start after reset
   always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         sync_prev <= 1'b0;
         boot_start <= 1'b1;
      end else begin
         sync_prev <= sync_lvl;
         boot_start <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Divider 2 core
   // ---------------------------------------------------------------
   wire div2_level;
   wire div2_running;

   ocd_div_core u_div2 (
      .clk_in(SYS_CLK_IN),
      .rst_in(SYS_RST_IN),
      .hold_in(div_hold),
      .restart_in(div_restart),
      .low_cnt_in(div2_cycle_counts[`OCD_CNT_LOW]),
      .high_cnt_in(div2_cycle_counts[`OCD_CNT_HIGH]),
      .start_high_in(div2_control[`OCD_CTL_START]),
      .phase_in(div2_control[`OCD_CTL_PHASE]),
      .level_out(div2_level),
      .running_out(div2_running)
   );

   // ---------------------------------------------------------------
   // Divider input image for bypass
   // ---------------------------------------------------------------
   reg in_phase;

   // Toggles every input cycle; stands for the undivided input clock
   always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         in_phase <= 1'b0;
      end else begin
         in_phase <= ~in_phase;
      end
   end

   // ---------------------------------------------------------------
   // Divider 2 output selection
   // ---------------------------------------------------------------
   reg div2_out;

   // Bypass first, then forced static level, then divided clock
   always @* begin
      if (div2_control[`OCD_CTL_BYPASS]) begin
         div2_out = in_phase;
      end else if (div2_control[`OCD_CTL_NOSYNC]) begin
         div2_out = div2_control[`OCD_CTL_FORCE];
      end else begin
         div2_out = div2_level;
      end
   end

   // ---------------------------------------------------------------
   // Direct routing of the pairs
   // ---------------------------------------------------------------
   reg pair_b_next;
   reg pair_c_next;
   wire [1:0] route_sel;

   assign route_sel = input_select[`OCD_SEL_FIELD];

   // Pair B follows divider 1 unless routed straight to VCO or external clock
   always @* begin
      pair_b_next = DIV1_LEVEL_IN;
      if (div1_route_and_duty[`OCD_RT_DIRECT]) begin
         if (route_sel == `OCD_ROUTE_VCO) begin
            pair_b_next = vco_lvl;
         end else if (route_sel == `OCD_ROUTE_EXT) begin
            pair_b_next = ext_lvl;
         end
      end
   end

   // Pair C follows divider 2 unless routed straight to VCO or external clock
   always @* begin
      pair_c_next = div2_out;
      if (div2_route_and_duty[`OCD_RT_DIRECT]) begin
         if (route_sel == `OCD_ROUTE_VCO) begin
            pair_c_next = vco_lvl;
         end else if (route_sel == `OCD_ROUTE_EXT) begin
            pair_c_next = ext_lvl;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------

   // Both members of a pair load the same selected clock
   always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         PAIR_B_OUTPUT_A_OUT <= 1'b0;
         PAIR_B_OUTPUT_B_OUT <= 1'b0;
         PAIR_C_OUTPUT_A_OUT <= 1'b0;
         PAIR_C_OUTPUT_B_OUT <= 1'b0;
      end else begin
         PAIR_B_OUTPUT_A_OUT <= pair_b_next;
         PAIR_B_OUTPUT_B_OUT <= pair_b_next;
         PAIR_C_OUTPUT_A_OUT <= pair_c_next;
         PAIR_C_OUTPUT_B_OUT <= pair_c_next;
      end
   end

   // Correction disables and VCO divider source controls
   always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         DUTY_CORRECTION_DISABLE_OUT <= 2'h0;
         VCO_DIV_SRC_VCO_OUT <= 1'b0;
         VCO_DIV_BYPASS_OUT <= 1'b0;
      end else begin
         DUTY_CORRECTION_DISABLE_OUT <= {div2_route_and_duty[`OCD_RT_DCC_OFF],
            div1_route_and_duty[`OCD_RT_DCC_OFF]};
         VCO_DIV_SRC_VCO_OUT <= input_select[`OCD_SEL_VCO];
         VCO_DIV_BYPASS_OUT <= input_select[`OCD_SEL_BYP];
      end
   end

   // ---------------------------------------------------------------
   // Status byte
   // ---------------------------------------------------------------
   // Bit 0 pair B level, bit 1 pair C level, bit 2 divider 2 running,
   // bit 3 divider 2 held by sync, bit 4 cleaned sync level
   assign status_byte = {3'h0, sync_lvl, div_hold, div2_running,
      PAIR_C_OUTPUT_A_OUT, PAIR_B_OUTPUT_A_OUT};

endmodule

/* ocd_channel_props.sv */
// Port-level assertions for the output divider channel
`timescale 1ns/100ps
module ocd_channel_props (
   input wire SYS_CLK_IN,
   input wire SYS_RST_IN,
   input wire WB_CYC_IN,
   input wire WB_STB_IN,
   input wire WB_WE_IN,
   input wire [11:0] WB_ADR_IN,
   input wire [3:0] WB_SEL_IN,
   input wire [31:0] WB_DAT_IN,
   input wire WB_ACK_OUT,
   input wire SYNC_REQ_IN,
   input wire PAIR_B_OUTPUT_A_OUT,
   input wire PAIR_B_OUTPUT_B_OUT,
   input wire PAIR_C_OUTPUT_A_OUT,
   input wire PAIR_C_OUTPUT_B_OUT,
   input wire VCO_DIV_SRC_VCO_OUT,
   input wire VCO_DIV_BYPASS_OUT
);
   // ---------------------------------------------------------------
   // Shadow of written settings and run counters
   // ---------------------------------------------------------------
   reg [7:0] cnt, ctl;
   reg [1:0] sel;
   reg rt2, pc;
   reg [6:0] qt, sq, sh, rl;
   wire w = WB_CYC_IN & WB_STB_IN & WB_WE_IN & ~WB_ACK_OUT & WB_SEL_IN[0];
   wire [9:0] ix = WB_ADR_IN[11:2];
   wire dv = ~(rt2 & (sel != 2'h1)); // Divider 2 feeds pair C
   wire run = dv & ~ctl[7] & ~ctl[6] & (rl < 7'h20) & (qt > rl + 7'h18) & (sq > rl + 7'h18);

   function [6:0] inc(input [6:0] v);
      inc = (v == 7'h7F) ? v : v + 7'h01;
   endfunction

   // Track writes, quiet time, sync levels and output run length
   always @(posedge SYS_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         cnt <= 8'h00;
         ctl <= 8'h00;
         sel <= 2'h0;
         rt2 <= 1'b0;
         pc <= 1'b0;
         qt <= 7'h00;
         sq <= 7'h00;
         sh <= 7'h00;
         rl <= 7'h00;
      end else begin
         if (w && ix == 10'h196) cnt <= WB_DAT_IN[7:0];
         if (w && ix == 10'h197) ctl <= WB_DAT_IN[7:0];
         if (w && ix == 10'h198) rt2 <= WB_DAT_IN[1];
         if (w && ix == 10'h1E1) sel <= WB_DAT_IN[1] ? 2'h2 : WB_DAT_IN[1:0];
         qt <= w ? 7'h00 : inc(qt);
         sq <= SYNC_REQ_IN ? 7'h00 : inc(sq);
         sh <= SYNC_REQ_IN ? inc(sh) : 7'h00;
         pc <= PAIR_C_OUTPUT_A_OUT;
         rl <= (PAIR_C_OUTPUT_A_OUT != pc) ? 7'h01 : inc(rl);
      end
   end

   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   ack_answer_a:
      assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
      else $error("no ack one cycle after request");
   ack_pulse_a:
      assert property (WB_ACK_OUT |=> !WB_ACK_OUT) else $error("ack longer than one cycle");
   pair_same_a:
      assert property (PAIR_B_OUTPUT_A_OUT == PAIR_B_OUTPUT_B_OUT
         && PAIR_C_OUTPUT_A_OUT == PAIR_C_OUTPUT_B_OUT) else $error("pair outputs differ");
   sel_excl_a:
      assert property (!(VCO_DIV_SRC_VCO_OUT && VCO_DIV_BYPASS_OUT))
      else $error("source select and bypass both set");
   high_len_a:
      assert property ($changed(PAIR_C_OUTPUT_A_OUT) && run && $past(PAIR_C_OUTPUT_A_OUT)
         |-> rl == {3'h0, cnt[3:0]} + 7'h01) else $error("high phase length wrong");
   low_len_a:
      assert property ($changed(PAIR_C_OUTPUT_A_OUT) && run && !$past(PAIR_C_OUTPUT_A_OUT)
         |-> rl == {3'h0, cnt[7:4]} + 7'h01) else $error("low phase length wrong");
   force_static_a:
      assert property (qt > 7'h08 && ctl[6] && !ctl[7] && dv
         |-> PAIR_C_OUTPUT_A_OUT == ctl[5]) else $error("forced level wrong");
   bypass_tog_a:
      assert property (qt > 7'h08 && !w && ctl[7] && dv |=> $changed(PAIR_C_OUTPUT_A_OUT))
      else $error("bypass output not following clock");
   sync_hold_a:
      assert property (sh > 7'h06 && qt > 7'h08 && !ctl[6] && !ctl[7] && dv
         |-> PAIR_C_OUTPUT_A_OUT == ctl[4]) else $error("start level not held in sync");

   cover property (WB_ACK_OUT && !WB_WE_IN);
   cover property (sh > 7'h06 && !ctl[6]);
   cover property (qt > 7'h08 && ctl[7]);
endmodule

bind ocd_channel ocd_channel_props i_props (.SYS_CLK_IN(SYS_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
   .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
   .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN), .WB_ACK_OUT(WB_ACK_OUT),
   .SYNC_REQ_IN(SYNC_REQ_IN), .PAIR_B_OUTPUT_A_OUT(PAIR_B_OUTPUT_A_OUT),
   .PAIR_B_OUTPUT_B_OUT(PAIR_B_OUTPUT_B_OUT), .PAIR_C_OUTPUT_A_OUT(PAIR_C_OUTPUT_A_OUT),
   .PAIR_C_OUTPUT_B_OUT(PAIR_C_OUTPUT_B_OUT), .VCO_DIV_SRC_VCO_OUT(VCO_DIV_SRC_VCO_OUT),
   .VCO_DIV_BYPASS_OUT(VCO_DIV_BYPASS_OUT));

/* ocd_channel_tb.sv */
// Self-checking bench for the output divider channel
`timescale 1ns/100ps
module ocd_channel_tb;
   reg clk, rst, cyc, stb, we, vco, ext, syn, d1, v;
   reg [11:0] adr;
   reg [3:0] sel, msk;
   reg [31:0] dat;
   wire [31:0] rdo;
   wire ack, pba, pbb, pca, pcb, src, byp;
   wire [1:0] dcc;
   integer n_fail, cmp_count, a, b;

   // Device under test
   ocd_channel i_ocd_channel (.SYS_CLK_IN(clk), .SYS_RST_IN(rst), .WB_CYC_IN(cyc),
      .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(dat),
      .WB_DAT_OUT(rdo), .WB_ACK_OUT(ack), .VCO_CLK_IN(vco), .EXT_CLK_IN(ext),
      .SYNC_REQ_IN(syn), .DIV1_LEVEL_IN(d1), .PAIR_B_OUTPUT_A_OUT(pba),
      .PAIR_B_OUTPUT_B_OUT(pbb), .PAIR_C_OUTPUT_A_OUT(pca), .PAIR_C_OUTPUT_B_OUT(pcb),
      .DUTY_CORRECTION_DISABLE_OUT(dcc), .VCO_DIV_SRC_VCO_OUT(src), .VCO_DIV_BYPASS_OUT(byp));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ---------------------------------------------------------------
   // Reporting and bus tasks
   // ---------------------------------------------------------------
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
         if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask

   task chk(input [31:0] got, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask

   task tmo(input integer k);
      if (k >= 99) begin
         n_fail = n_fail + 1;
         close_out;
      end
   endtask

   // One classic cycle, held until ack is sampled high
   task bus(input w, input [9:0] i, input [7:0] d);
      integer k;
      begin
         @(posedge clk);
         cyc <= 1'b1;
         stb <= 1'b1;
         we <= w;
         sel <= msk;
         adr <= {i, 2'h0};
         dat <= {24'h000000, d};
         k = 0;
         @(posedge clk);
         while (ack !== 1'b1 && k < 99) begin
            @(posedge clk);
            k = k + 1;
         end
         tmo(k);
         cyc <= 1'b0;
         stb <= 1'b0;
      end
   endtask

   task rc(input [9:0] i, input [7:0] e);
      begin
         bus(1'b0, i, 8'h00);
         chk(rdo, {24'h000000, e});
      end
   endtask

   // Edges spent high then low in one full output period
   task meas(output integer h, output integer l);
      integer k;
      begin
         k = 0;
         h = 0;
         l = 0;
         while (pca !== 1'b0 && k < 99) begin @(posedge clk); k = k + 1; end
         while (pca !== 1'b1 && k < 99) begin @(posedge clk); k = k + 1; end
         while (pca === 1'b1 && k < 99) begin @(posedge clk); k = k + 1; h = h + 1; end
         while (pca === 1'b0 && k < 99) begin @(posedge clk); k = k + 1; l = l + 1; end
         tmo(k);
      end
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_regs;
      begin
         rc(10'h195, 8'h00);
         rc(10'h196, 8'h00);
         rc(10'h197, 8'h00);
         rc(10'h198, 8'h00);
         rc(10'h1E1, 8'h00);
         bus(1'b1, 10'h196, 8'hA5);
         msk = 4'hE;
         bus(1'b1, 10'h196, 8'h33);
         msk = 4'hF;
         rc(10'h196, 8'hA5);
         bus(1'b1, 10'h100, 8'h5A);
         rc(10'h100, 8'h00);
         bus(1'b1, 10'h195, 8'hFD);
         bus(1'b1, 10'h198, 8'h01);
         rc(10'h195, 8'h01);
         chk(dcc, 32'h3);
         bus(1'b1, 10'h195, 8'h00);
         bus(1'b1, 10'h198, 8'h00);
         bus(1'b1, 10'h1E1, 8'h03);
         rc(10'h1E1, 8'h02);
         chk({src, byp, dcc}, 32'h8);
         bus(1'b1, 10'h1E1, 8'h01);
         bus(1'b1, 10'h1E1, 8'h01);
         chk({src, byp}, 32'h1);
         bus(1'b1, 10'h1E1, 8'h00);
      end
   endtask

   task t_div(input [7:0] cv);
      begin
         bus(1'b1, 10'h196, cv);
         repeat (40) @(posedge clk);
         meas(a, b);
         chk(a, {28'h0, cv[3:0]} + 32'h1);
         chk(b, {28'h0, cv[7:4]} + 32'h1);
      end
   endtask

   // Hold sync, check start level, count edges to the first change
   task rs(input [7:0] cv, output integer n);
      begin
         bus(1'b1, 10'h197, cv);
         @(posedge clk);
         syn <= 1'b1;
         repeat (12) @(posedge clk);
         chk(pca, {31'h0, cv[4]});
         syn <= 1'b0;
         n = 0;
         while (pca === cv[4] && n < 99) begin @(posedge clk); n = n + 1; end
         tmo(n);
      end
   endtask

   task t_sync;
      begin
         bus(1'b1, 10'h196, 8'h11);
         rs(8'h10, a);
         rs(8'h13, b);
         chk(b - a, 32'h3);
         rs(8'h00, a);
         rs(8'h0F, b);
         chk(b - a, 32'hF);
      end
   endtask

   task t_nosync;
      begin
         bus(1'b1, 10'h197, 8'h60);
         @(posedge clk);
         syn <= 1'b1;
         repeat (12) @(posedge clk);
         chk({pca, pcb}, 32'h3);
         rc(10'h1F0, 8'h16);
         syn <= 1'b0;
         bus(1'b1, 10'h197, 8'h40);
         repeat (4) @(posedge clk);
         chk(pca, 32'h0);
         bus(1'b1, 10'h197, 8'hE0);
         repeat (12) @(posedge clk);
         v = pca;
         @(posedge clk);
         chk(pca, {31'h0, ~v});
         // Force bit alone, sync obeyed: the divided clock must keep running
         bus(1'b1, 10'h197, 8'h20);
         repeat (8) @(posedge clk);
         meas(a, b);
         chk(a, 32'h2);
         chk(b, 32'h2);
         bus(1'b1, 10'h197, 8'h40);
      end
   endtask

   // Route check: select code, pin levels, then expected pair B and C
   task rt(input [1:0] s, input iv, input ie, input id, input xb, input xc);
      begin
         bus(1'b1, 10'h1E1, {6'h00, s});
         @(posedge clk);
         vco <= iv;
         ext <= ie;
         d1 <= id;
         repeat (8) @(posedge clk);
         chk({pba, pbb, pca, pcb}, {28'h0, xb, xb, xc, xc});
      end
   endtask

   task t_route;
      begin
         bus(1'b1, 10'h195, 8'h02);
         bus(1'b1, 10'h198, 8'h02);
         rt(2'h2, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
         rt(2'h2, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
         rt(2'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
         rt(2'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
         rt(2'h1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
         bus(1'b1, 10'h195, 8'h00);
         bus(1'b1, 10'h198, 8'h00);
         rt(2'h2, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
         rt(2'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      end
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      {cyc, stb, we, vco, ext, syn, d1, v} = 8'h00;
      adr = 12'h000;
      sel = 4'h0;
      msk = 4'hF;
      dat = 32'h00000000;
      n_fail = 0;
      cmp_count = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_div(8'h23);
      t_div(8'h0F);
      t_div(8'hF0);
      t_div(8'h00);
      t_sync;
      t_nosync;
      t_route;
      close_out;
   end
endmodule
